//--- src/qp_sram_core.sv
`timescale 1ns/1ps
`include "qp_sram_defines.svh"

// Summary of operation
// - each lane's four beats form one 36-bit storage word at the address
// - mask low on both beats stores both beats of the lane
// - mask low then high stores only the first beat
// - mask high then low stores second beat; high both leaves lane unchanged
// - mask n covers data bits [9n+8:9n]; lanes 2 and 3 only when wide
// - any half write disables error correction
// - error correction stays disabled until power is removed
// - command sampled each cycle: read low reads, write low with read high writes, else deselect
// - read after read and write after write are ignored
// - write beats taken on the four half cycles after the command
// - read beats delivered 2 and 3 cycles after the command
// - outputs float two cycles after deselect or write unless previous was read
// - slots past a deselect's first two belong to the following command
// - free cycle counter periodically triggers an impedance evaluation
// - each evaluation moves drive setting by at most one step
// - drive strength is a binary-weighted segment code
//
// one ref_clk cycle is one input clock cycle; each beat port carries the
// true-clock half (rise) and the complement half (fall) of that cycle.
module qp_sram_core #(
    parameter int unsigned LANES   = 2,
    parameter int unsigned ADDR_W  = 10,
    parameter int unsigned ZPERIOD = `ZCAL_PERIOD
) (
    input  wire logic                              ref_clk,
    input  wire logic                              srst,
    input  wire logic [ADDR_W-1:0]                 addr,
    input  wire logic                              readN,
    input  wire logic                              writeN,
    input  wire logic [LANES*`LANE_BITS-1:0]       dataRise,
    input  wire logic [LANES*`LANE_BITS-1:0]       dataFall,
    input  wire logic [LANES-1:0]                  lane_write_mask_n_rise,
    input  wire logic [LANES-1:0]                  lane_write_mask_n_fall,
    input  wire logic                              impedance_sense_pin,
    output logic      [LANES*`LANE_BITS-1:0]       qRise,
    output logic      [LANES*`LANE_BITS-1:0]       qFall,
    output logic                                   qDriveOe,
    output logic                                   eccEnabled,
    output logic      [`ZCAL_CODE_BITS-1:0]        driveCode
);
    localparam int unsigned LW    = LANES * `LANE_BITS;
    localparam int unsigned DEPTH = 1 << ADDR_W;

    // --------------------------------------------------------------
    // storage: each lane keeps its own rows, one row per half burst
    // --------------------------------------------------------------
    // rise and fall beats of all lanes gathered at the read index
    wire [LW-1:0] rdHi;
    wire [LW-1:0] rdLo;

    // --------------------------------------------------------------
    // input synchronisers for the comparator pin
    // --------------------------------------------------------------
    logic [2:0] senseSync_r;
    logic       senseState_r;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            senseSync_r  <= 3'h0;
            senseState_r <= 1'b0;
        end
        else
        begin
            senseSync_r <= {senseSync_r[1:0], impedance_sense_pin};
            if (senseSync_r[1] == senseSync_r[2])
                senseState_r <= senseSync_r[2];
        end
    end

    // settled high: drive too weak; settled low: drive too strong
    // evaluation cadence and the one-step limit live in the counter
    zcal_counter #(
        .PERIOD (ZPERIOD)
    ) u_zcal (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .tooWeak   (senseState_r),
        .tooStrong (!senseState_r),
        .driveCode (driveCode)
    );

    // --------------------------------------------------------------
    // command decode and pipeline
    // --------------------------------------------------------------
    qp_sram_pkg::cmd_t           prev_r;
    qp_sram_pkg::cmd_t           prev_nxt;
    logic [1:0]                  wrPhase_r;
    logic [1:0]                  wrPhase_nxt;
    logic [ADDR_W-1:0]           wrAddr_r;
    logic [ADDR_W-1:0]           wrAddr_nxt;
    logic [1:0]                  rdPhase_r;
    logic [1:0]                  rdPhase_nxt;
    logic [ADDR_W-1:0]           rdAddr_r;
    logic [ADDR_W-1:0]           rdAddr_nxt;
    logic                        ecc_r;
    logic                        ecc_nxt;
    logic                        halfSeen;
    logic                        doRead;
    logic                        doWrite;

    // a refused command leaves prev at idle, so the next one is taken
    always_comb
    begin
        doRead  = !readN && prev_r != qp_sram_pkg::CMD_READ;
        doWrite = readN && !writeN && prev_r != qp_sram_pkg::CMD_WRITE;
        prev_nxt = doRead ? qp_sram_pkg::CMD_READ :
                   doWrite ? qp_sram_pkg::CMD_WRITE : qp_sram_pkg::CMD_IDLE;
        // write tail keeps running while a read starts
        wrPhase_nxt = doWrite ? 2'h1 : (wrPhase_r == 2'h2 ? 2'h0 :
                      (wrPhase_r != 2'h0 ? wrPhase_r + 2'h1 : 2'h0));
        wrAddr_nxt  = doWrite ? addr : wrAddr_r;
        // read phase 1 sends beats 0/1, phase 2 sends beats 2/3
        rdPhase_nxt = doRead ? 2'h1 : (rdPhase_r == 2'h1 ? 2'h2 : 2'h0);
        rdAddr_nxt  = doRead ? addr : rdAddr_r;
        halfSeen = 1'b0;
        if (wrPhase_r != 2'h0)
            halfSeen = |(lane_write_mask_n_rise ^ lane_write_mask_n_fall);
        // only ever cleared here; srst stands in for removing power
        ecc_nxt = ecc_r && !halfSeen;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prev_r    <= qp_sram_pkg::CMD_IDLE;
            wrPhase_r <= 2'h0;
            wrAddr_r  <= '0;
            rdPhase_r <= 2'h0;
            rdAddr_r  <= '0;
            ecc_r     <= 1'b1;
        end
        else
        begin
            prev_r    <= prev_nxt;
            wrPhase_r <= wrPhase_nxt;
            wrAddr_r  <= wrAddr_nxt;
            rdPhase_r <= rdPhase_nxt;
            rdAddr_r  <= rdAddr_nxt;
            ecc_r     <= ecc_nxt;
        end
    end

    // --------------------------------------------------------------
    // byte-masked array writes, one beat pair per lane
    // --------------------------------------------------------------
    logic [ADDR_W:0] wrIdx;
    logic [ADDR_W:0] rdIdx;

    assign wrIdx = {wrAddr_r, wrPhase_r == 2'h2};
    assign rdIdx = {rdAddr_r, rdPhase_r == 2'h2};

    // each lane owns its rows, so every array has a single writing process
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : gLane
            logic [`LANE_BITS-1:0] laneHi [0:DEPTH*2-1];
            logic [`LANE_BITS-1:0] laneLo [0:DEPTH*2-1];

            assign rdHi[g*`LANE_BITS +: `LANE_BITS] = laneHi[rdIdx];
            assign rdLo[g*`LANE_BITS +: `LANE_BITS] = laneLo[rdIdx];

            always_ff @(posedge ref_clk)
            begin
                if (wrPhase_r != 2'h0)
                begin
                    if (!lane_write_mask_n_rise[g])
                        laneHi[wrIdx] <=
                            dataRise[g*`LANE_BITS +: `LANE_BITS];
                    if (!lane_write_mask_n_fall[g])
                        laneLo[wrIdx] <=
                            dataFall[g*`LANE_BITS +: `LANE_BITS];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // read output registers and drive enable
    // --------------------------------------------------------------
    logic [LW-1:0] qRise_nxt;
    logic [LW-1:0] qFall_nxt;
    logic          oe_nxt;

    always_comb
    begin
        // true-clock beat leads here: qRise then qFall of the same cycle
        // a refused read does not restart rdPhase, so no extra beats appear
        oe_nxt    = rdPhase_r != 2'h0;
        // undriven cycles show zero so stale beats never linger
        qRise_nxt = oe_nxt ? rdHi : '0;
        qFall_nxt = oe_nxt ? rdLo : '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            qRise    <= '0;
            qFall    <= '0;
            qDriveOe <= 1'b0;
        end
        else
        begin
            qRise    <= qRise_nxt;
            qFall    <= qFall_nxt;
            qDriveOe <= oe_nxt;
        end
    end

    assign eccEnabled = ecc_r;
endmodule

//--- src/qp_sram_defines.svh
`ifndef QP_SRAM_DEFINES_SVH
`define QP_SRAM_DEFINES_SVH

`define LANE_BITS        9
`define ZCAL_PERIOD      32'h0000_4000
`define ZCAL_CODE_BITS   5
`define ZCAL_CODE_RESET  5'h10
`define ZCAL_MIN_CODE    5'h00
`define ZCAL_MAX_CODE    5'h1f

`endif

//--- src/qp_sram_pkg.sv
package qp_sram_pkg;

    typedef enum logic [1:0]
    {
        CMD_IDLE  = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_READ  = 2'b11
    } cmd_t;

    typedef struct packed
    {
        logic readN;
        logic writeN;
    } cmd_pins_t;

endpackage

//--- src/zcal_counter.sv
`timescale 1ns/1ps
`include "qp_sram_defines.svh"

module zcal_counter #(
    parameter int unsigned PERIOD = `ZCAL_PERIOD
) (
    input  wire logic                         ref_clk,
    input  wire logic                         srst,
    input  wire logic                         tooWeak,
    input  wire logic                         tooStrong,
    output logic      [`ZCAL_CODE_BITS-1:0]   driveCode
);
    logic [31:0]                 count_r;
    logic [31:0]                 count_nxt;
    logic [`ZCAL_CODE_BITS-1:0]  code_r;
    logic [`ZCAL_CODE_BITS-1:0]  code_nxt;

    assign driveCode = code_r;

    always_comb
    begin
        count_nxt = count_r - 32'h0000_0001;
        code_nxt  = code_r;
        if (count_r == 32'h0000_0000)
        begin
            count_nxt = PERIOD - 1;
            if (tooWeak && code_r != `ZCAL_MAX_CODE)
                code_nxt = code_r + 5'h01;
            else if (tooStrong && code_r != `ZCAL_MIN_CODE)
                code_nxt = code_r - 5'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            count_r <= PERIOD - 1;
            code_r  <= `ZCAL_CODE_RESET;
        end
        else
        begin
            count_r <= count_nxt;
            code_r  <= code_nxt;
        end
    end
endmodule

//--- verif/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic        ref_clk,
    output logic      [9:0]  addr,
    output logic             readN,
    output logic             writeN,
    output logic      [35:0] dataRise,
    output logic      [35:0] dataFall,
    output logic      [3:0]  maskNRise,
    output logic      [3:0]  maskNFall
);
    initial
        {addr, readN, writeN, dataRise, dataFall, maskNRise, maskNFall} = '1;
    // ----
    // one controller cycle, launched just after the rising edge
    // ----
    task automatic step(input logic rN, input logic wN, input logic [9:0] a,
        input logic [35:0] r, input logic [35:0] f, input logic [3:0] mr, input logic [3:0] mf);
        @(posedge ref_clk);
        #1;
        readN = rN;
        writeN = wN;
        addr = a;
        maskNRise = mr;
        maskNFall = mf;
        // unused beat slots toggle so stale data cannot pass
        dataRise = (mr & mf) == 4'hf ? ~dataRise : r;
        dataFall = (mr & mf) == 4'hf ? ~dataFall : f;
    endtask
endmodule

//--- verif/qp_sram_chk.sv
`timescale 1ns/1ps
`include "qp_sram_defines.svh"
module qp_sram_chk #(parameter int unsigned LANES = 2) (
    input wire logic                       ref_clk,
    input wire logic                       srst,
    input wire logic                       readN,
    input wire logic                       writeN,
    input wire logic [LANES-1:0]           lane_write_mask_n_rise,
    input wire logic [LANES-1:0]           lane_write_mask_n_fall,
    input wire logic                       qDriveOe,
    input wire logic                       eccEnabled,
    input wire logic [`ZCAL_CODE_BITS-1:0] driveCode
);
    logic       lastRd_r;
    logic       lastWr_r;
    logic [2:0] rdSh_r;
    logic [1:0] wrSh_r;
    wire        rdTk = !readN && !lastRd_r;
    wire        wrTk = readN && !writeN && !lastWr_r;
    // ----
    // commands as the device loads them
    // ----
    always_ff @(posedge ref_clk)
    begin
        lastRd_r <= !srst && rdTk;
        lastWr_r <= !srst && wrTk;
        rdSh_r   <= srst ? 3'h0 : {rdSh_r[1:0], rdTk};
        wrSh_r   <= srst ? 2'h0 : {wrSh_r[0], wrTk};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    code_step_a: assert property ($changed(driveCode) |->
        driveCode == $past(driveCode) + 5'h01 || driveCode == $past(driveCode) - 5'h01)
        else $error("drive code moved by more than one step");
    code_pace_a: assert property ($changed(driveCode) |=> $stable(driveCode) [*8])
        else $error("drive code changed too soon");
    ecc_hold_a: assert property (!eccEnabled |=> !eccEnabled)
        else $error("error correction came back on");
    half_ecc_a: assert property ((|wrSh_r) &&
        (|(lane_write_mask_n_rise ^ lane_write_mask_n_fall)) |-> ##[1:3] !eccEnabled)
        else $error("half write left error correction on");
    rd_drive_a: assert property (rdSh_r[1] || rdSh_r[2] |-> qDriveOe)
        else $error("read beats not driven");
    oe_cause_a: assert property (qDriveOe |-> rdSh_r[1] || rdSh_r[2])
        else $error("outputs driven outside read beats");
    ecc_reset_a: assert property ($fell(srst) |-> eccEnabled && !qDriveOe)
        else $error("bad state after reset");
    code_reset_a: assert property ($fell(srst) |-> driveCode == `ZCAL_CODE_RESET)
        else $error("drive code not at reset value");
    cover property (wrTk ##1 rdTk);
    cover property (wrTk ##1 (readN && !writeN));
    cover property ($fell(eccEnabled));
endmodule

bind qp_sram_core qp_sram_chk #(.LANES(LANES)) u_qp_sram_chk (.ref_clk(ref_clk), .srst(srst),
    .readN(readN), .writeN(writeN), .lane_write_mask_n_rise(lane_write_mask_n_rise),
    .lane_write_mask_n_fall(lane_write_mask_n_fall), .qDriveOe(qDriveOe),
    .eccEnabled(eccEnabled), .driveCode(driveCode));

//--- verif/quad_port_sram_cmd_bytemask_tb.sv
`timescale 1ns/1ps
module quad_port_sram_cmd_bytemask_tb;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        senseIn = 1'b0;
    logic [9:0]  addr;
    logic        readN, writeN, qDriveOe, eccEnabled;
    logic [35:0] dataRise, dataFall, qRise, qFall;
    logic [3:0]  maskNRise, maskNFall;
    logic [4:0]  driveCode, codeSeen;
    logic [35:0] wd [4], ex [4], a1 [4];
    logic [3:0]  wm [4];
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #4 ref_clk = ~ref_clk;
    ctrl_model u_ctrl_model (.ref_clk(ref_clk), .addr(addr), .readN(readN), .writeN(writeN),
        .dataRise(dataRise), .dataFall(dataFall), .maskNRise(maskNRise), .maskNFall(maskNFall));
    qp_sram_core #(.LANES(4), .ADDR_W(10), .ZPERIOD(16)) u_qp_sram_core (.ref_clk(ref_clk),
        .srst(srst), .addr(addr), .readN(readN), .writeN(writeN), .dataRise(dataRise),
        .dataFall(dataFall), .lane_write_mask_n_rise(maskNRise),
        .lane_write_mask_n_fall(maskNFall), .impedance_sense_pin(senseIn), .qRise(qRise),
        .qFall(qFall), .qDriveOe(qDriveOe), .eccEnabled(eccEnabled), .driveCode(driveCode));
    // ----
    // checking and bus helpers
    // ----
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) u_ctrl_model.step(1'b1, 1'b1, 10'h000, '1, '1, 4'hf, 4'hf);
    endtask
    task automatic fill(input logic [7:0] s, input logic [3:0] r0, input logic [3:0] f0,
        input logic [3:0] r1, input logic [3:0] f1);
        for (int i = 0; i < 4; i++)
            wd[i] = 36'h0_0804_0201 * (s + i) ^ 36'h1_2345_6789;
        wm = '{r0, f0, r1, f1};
    endtask
    // expected address 1 contents: masked lanes keep the old byte
    task automatic upd();
        for (int i = 0; i < 4; i++)
            a1[i] = (wd[i] & ~{{9{wm[i][3]}}, {9{wm[i][2]}}, {9{wm[i][1]}}, {9{wm[i][0]}}})
                | (a1[i] & {{9{wm[i][3]}}, {9{wm[i][2]}}, {9{wm[i][1]}}, {9{wm[i][0]}}});
    endtask
    task automatic rw(input logic [9:0] wa, input logic [9:0] ra, input bit ce);
        u_ctrl_model.step(1'b1, 1'b0, wa, '1, '1, 4'hf, 4'hf);
        u_ctrl_model.step(1'b0, 1'b1, ra, wd[0], wd[1], wm[0], wm[1]);
        chk(36'(qDriveOe), 36'h0);
        u_ctrl_model.step(1'b1, 1'b1, ra, wd[2], wd[3], wm[2], wm[3]);
        idle(1);
        for (int h = 0; h < 2; h++)
        begin
            if (ce)
            begin
                chk(qRise, ex[2*h]);
                chk(qFall, ex[2*h+1]);
            end
            chk(36'(qDriveOe), 36'h1);
            idle(1);
        end
        chk(36'(qDriveOe), 36'h0);
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk(36'(driveCode), 36'h10);
        fill(8'h11, 4'h0, 4'h0, 4'h0, 4'h0);
        rw(10'h001, 10'h002, 1'b0);
        upd();
        ex = a1;
        fill(8'h22, 4'h0, 4'h0, 4'h0, 4'h0);
        rw(10'h002, 10'h001, 1'b1);
        ex = wd;
        fill(8'h33, 4'h5, 4'h5, 4'h3, 4'h3);
        rw(10'h001, 10'h002, 1'b1);
        upd();
        u_ctrl_model.step(1'b1, 1'b0, 10'h002, '1, '1, 4'hf, 4'hf);
        u_ctrl_model.step(1'b1, 1'b0, 10'h001, wd[0], wd[1], 4'h0, 4'h0);
        u_ctrl_model.step(1'b0, 1'b1, 10'h002, wd[2], wd[3], 4'h0, 4'h0);
        u_ctrl_model.step(1'b0, 1'b1, 10'h001, '1, '1, 4'hf, 4'hf);
        idle(1);
        chk(qRise, wd[0]);
        chk(qFall, wd[1]);
        idle(1);
        chk(qRise, wd[2]);
        chk(qFall, wd[3]);
        idle(1);
        chk(36'(qDriveOe), 36'h0);
        idle(1);
        ex = a1;
        chk(36'(eccEnabled), 36'h1);
        rw(10'h005, 10'h001, 1'b1);
        fill(8'h44, 4'he, 4'hd, 4'h0, 4'h0);
        rw(10'h001, 10'h005, 1'b0);
        upd();
        chk(36'(eccEnabled), 36'h0);
        ex = a1;
        rw(10'h005, 10'h001, 1'b1);
        idle(20);
        chk(36'(eccEnabled), 36'h0);
        codeSeen = driveCode;
        senseIn = 1'b1;
        idle(80);
        chk(36'(driveCode > codeSeen), 36'h1);
        codeSeen = driveCode;
        senseIn = 1'b0;
        idle(80);
        chk(36'(driveCode < codeSeen), 36'h1);
        srst = 1'b1;
        idle(10);
        srst = 1'b0;
        chk(36'(eccEnabled), 36'h1);
        chk(36'(driveCode), 36'h10);
        final_report();
    end
endmodule
